/* File: verilog/psl_strap_top.sv */
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
// What this block does
// - At reset the pins rxd3, rxd2, rxd1 are latched as station address bits 0, 1, 2.
// - At reset pin rxd0 is latched into the duplex bit, bit 8 of control register 0h.
// - At reset the receive-valid pin is latched as interface mode bit 2.
// - At reset the receive-error pin is latched as the initial isolate setting.
// - The interrupt output is active low unless bit 9 of register 1Fh selects high.
// - Register 1Bh holds interrupt enables and the interrupt status flags.
// - The management clock comes from the controller and data moves on its edges.
// - After reset the shared pins are driven as MII receive data, valid and error.
// - The receive and transmit clocks derive from the single 25 MHz reference clock; the core logic runs on core_clk.
// - The three mode bits decode to MII, RMII, SMII, preamble restore and back-to-back.
// - The latched isolate strap loads bit 10 of control register 0h.
// - The upper two station address bits are always zero.
module psl_strap_top (
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Reference clock for the link side
   input  wire logic        ref_clock_in,
   // Shared strap / receive pins
   input  wire logic [3:0]  rxdIn,
   input  wire logic        rxdvIn,
   input  wire logic        rxerIn,
   output logic      [3:0]  rxdOut,
   output logic             rxdvOut,
   output logic             rxerOut,
   output logic             rxPinsOe,
   output logic             rxClk,
   output logic             txClk,
   // Other mode strap bits and receive stream from the datapath
   input  wire logic [1:0]  ifModeLow,
   input  wire logic        rxActive,
   input  wire logic [3:0]  rxNibble,
   input  wire logic        rxBad,
   // Transmit inputs from the MAC
   input  wire logic        txEn,
   input  wire logic [3:0]  txData,
   // Management pins
   input  wire logic        mgmtClk,
   input  wire logic        mgmtDataIn,
   output logic             mgmtDataOut,
   output logic             mgmtDataOe,
   // Strap results
   output logic [4:0]       station_address,
   output psl_pkg::psl_mode_t ifMode,
   output logic             modeReserved,
   output logic             txEnSeen,
   // Interrupt pin
   output logic             irq_out,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [1:0] {PSL_SAMPLE, PSL_RUN} psl_phase_t;

   psl_phase_t phase_q;
   logic [7:0]  holdCnt_q;
   logic [5:0]  pinSync;
   logic [2:0]  addrStrap_q;
   logic [2:0]  modeStrap_q;
   logic [15:0] ctrl_q;
   logic [15:0] phyCtl_q;
   logic [7:0]  irqEn_q;
   logic [7:0]  irqSt_q;
   logic [7:0]  evSet;
   logic [7:0]  irqClr;
   logic [2:1]  mgmtSync;
   logic        mgmtClkPrev_q;
   logic        mgmtData_q;
   logic [1:0]  txSync;
   logic        irqAny;
   logic        linkRst;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        awHave_q;
   logic        wHave_q;
   logic        doWrite;
   logic        wrHit;

   // Strap pins are off-domain, so two flops before latching
   psl_sync #(.WIDTH(6)) u_pins (
      .clk     (core_clk),
      .srst    (1'b0),
      .asyncIn ({rxerIn, rxdvIn, rxdIn}),
      .syncOut (pinSync)
   );

   // Management clock/data and transmit pins synchronised too
   psl_sync #(.WIDTH(4)) u_mgmt (
      .clk     (core_clk),
      .srst    (srst),
      .asyncIn ({txEn, |txData, mgmtClk, mgmtDataIn}),
      .syncOut ({txSync, mgmtSync})
   );

   // Sampling window lasts through reset plus a short hold after release
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         phase_q   <= PSL_SAMPLE;
         holdCnt_q <= 8'h00;
      end
      else if (phase_q == PSL_SAMPLE)
      begin
         holdCnt_q <= holdCnt_q + 8'h01;
         if (holdCnt_q == 8'(psl_pkg::STRAP_HOLD_CYC))
            phase_q <= PSL_RUN;
      end
   end

   // Straps follow the pins while sampling, then freeze until next reset
   always_ff @(posedge core_clk)
   begin
      if (srst || phase_q == PSL_SAMPLE)
      begin
         addrStrap_q <= {pinSync[1], pinSync[2], pinSync[3]};
         modeStrap_q <= {pinSync[4], ifModeLow};
      end
   end

   assign station_address = {2'b00, addrStrap_q};

   // Mode decode; reserved codes flagged
   always_comb
   begin
      ifMode       = psl_pkg::psl_mode_t'(modeStrap_q);
      modeReserved = 1'b0;
      case (ifMode)
         psl_pkg::PSL_MODE_RSVD3,
         psl_pkg::PSL_MODE_RSVD7: modeReserved = 1'b1;
         default:                 modeReserved = 1'b0;
      endcase
   end

   // Link side held in reset through the sampling phase
   assign linkRst = (phase_q == PSL_SAMPLE);

   psl_mii_link u_link (
      .ref_clock_in (ref_clock_in),
      .linkRst      (linkRst),
      .rxActive     (rxActive),
      .rxNibble     (rxNibble),
      .rxBad        (rxBad),
      .rxClk        (rxClk),
      .txClk        (txClk),
      .rxData       (rxdOut),
      .rxDataValid  (rxdvOut),
      .rxErr        (rxerOut),
      .driveEn      (rxPinsOe)
   );

   // Transmit activity seen from the MAC; edge-timed by the MAC on txClk
   always_ff @(posedge core_clk)
   begin
      if (srst)
         txEnSeen <= 1'b0;
      else
         txEnSeen <= txSync[1] & ~txSync[0] | txSync[1];
   end

   // Management data captured on rising edges of the controller's clock
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mgmtClkPrev_q <= 1'b0;
         mgmtData_q    <= 1'b1;
      end
      else
      begin
         mgmtClkPrev_q <= mgmtSync[2];
         if (mgmtSync[2] && !mgmtClkPrev_q)
            mgmtData_q <= mgmtSync[1];
      end
   end

   // The frame engine is elsewhere; the pin is released to its pull-up
   assign mgmtDataOut = 1'b0;
   assign mgmtDataOe  = 1'b0;

   // AXI write: address and data taken in either order
   assign s_axi_awready = !awHave_q && !s_axi_bvalid;
   assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
   assign doWrite       = awHave_q && wHave_q && !s_axi_bvalid;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         awHave_q <= 1'b0;
         wHave_q  <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0;
         wStrb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         else if (doWrite)
            awHave_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         else if (doWrite)
            wHave_q <= 1'b0;
      end
   end

   assign wrHit = (awAddr_q == psl_pkg::CTRL_OFS) || (awAddr_q == psl_pkg::IRQ_OFS) ||
                  (awAddr_q == psl_pkg::PHYCTL_OFS) || (awAddr_q == psl_pkg::EVENT_OFS);

   // Write response; unmapped addresses get SLVERR
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= psl_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrHit ? psl_pkg::RESP_OKAY : psl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Control register: duplex and isolate loaded from straps until run
   always_ff @(posedge core_clk)
   begin
      if (srst || phase_q == PSL_SAMPLE)
      begin
         ctrl_q                          <= psl_pkg::CTRL_RST;
         ctrl_q[psl_pkg::DUPLEX_BIT]     <= pinSync[0];
         ctrl_q[psl_pkg::ISOLATE_BIT]    <= pinSync[5];
      end
      else if (doWrite && awAddr_q == psl_pkg::CTRL_OFS)
      begin
         if (wStrb_q[0])
            ctrl_q[7:0] <= wData_q[7:0];
         if (wStrb_q[1])
            ctrl_q[15:8] <= wData_q[15:8];
      end
   end

   // PHY control register holds the interrupt polarity
   always_ff @(posedge core_clk)
   begin
      if (srst)
         phyCtl_q <= psl_pkg::PHYCTL_RST;
      else if (doWrite && awAddr_q == psl_pkg::PHYCTL_OFS)
      begin
         if (wStrb_q[0])
            phyCtl_q[7:0] <= wData_q[7:0];
         if (wStrb_q[1])
            phyCtl_q[15:8] <= wData_q[15:8];
      end
   end

   // Events come from a software injection register in this block
   assign evSet  = (doWrite && awAddr_q == psl_pkg::EVENT_OFS && wStrb_q[0]) ?
                   wData_q[7:0] : 8'h00;
   assign irqClr = (s_axi_arvalid && s_axi_arready &&
                    s_axi_araddr == psl_pkg::IRQ_OFS) ? 8'hff : 8'h00;

   // Interrupt enables in the high byte, status in the low; read clears, set wins
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         irqEn_q <= psl_pkg::IRQEN_RST;
         irqSt_q <= 8'h00;
      end
      else
      begin
         if (doWrite && awAddr_q == psl_pkg::IRQ_OFS && wStrb_q[1])
            irqEn_q <= wData_q[15:8];
         irqSt_q <= (irqSt_q & ~irqClr) | evSet;
      end
   end

   assign irqAny = |(irqSt_q & irqEn_q);

   // Output polarity selected by software; registered to avoid glitches
   always_ff @(posedge core_clk)
   begin
      if (srst)
         irq_out <= 1'b1;
      else
         irq_out <= phyCtl_q[psl_pkg::IRQPOL_BIT] ? irqAny : ~irqAny;
   end

   // AXI read channel: one read at a time
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= psl_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= psl_pkg::RESP_OKAY;
         if (s_axi_araddr == psl_pkg::CTRL_OFS)
            s_axi_rdata <= {16'h0, ctrl_q};
         else if (s_axi_araddr == psl_pkg::IRQ_OFS)
            s_axi_rdata <= {16'h0, irqEn_q, irqSt_q};
         else if (s_axi_araddr == psl_pkg::PHYCTL_OFS)
            s_axi_rdata <= {16'h0, phyCtl_q};
         else if (s_axi_araddr == psl_pkg::STRAP_OFS)
            s_axi_rdata <= {16'h0, 4'h0, modeReserved, modeStrap_q,
                            mgmtData_q, phase_q == PSL_RUN, 1'b0, station_address};
         else
         begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= psl_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

/* File: verilog/psl_pkg.sv */
package psl_pkg;
   // AXI4-Lite register byte offsets (standard PHY register numbers times four)
   localparam logic [7:0] CTRL_OFS     = 8'h00; // Control register 0h
   localparam logic [7:0] IRQ_OFS      = 8'h6c; // Interrupt control/status 1Bh
   localparam logic [7:0] PHYCTL_OFS   = 8'h7c; // PHY control 1Fh
   localparam logic [7:0] STRAP_OFS    = 8'h80; // Latched straps (read only)
   localparam logic [7:0] EVENT_OFS    = 8'h84; // Event injection (write only)

   // Field positions
   localparam int DUPLEX_BIT   = 8;
   localparam int ISOLATE_BIT  = 10;
   localparam int IRQPOL_BIT   = 9;
   localparam int IRQ_EN_LSB   = 8;
   localparam int IRQ_NUM      = 8;

   // Reset values
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] PHYCTL_RST = 16'h0000;
   localparam logic [7:0]  IRQEN_RST  = 8'h00;

   // Timing
   localparam int REF_CLK_MHZ   = 25;
   localparam int CORE_CLK_MHZ  = 40;
   localparam int STRAP_HOLD_NS = 100;
   localparam int STRAP_HOLD_CYC =
      (STRAP_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Interface mode decode of the three latched mode bits
   typedef enum logic [2:0] {
      PSL_MODE_MII      = 3'h0,
      PSL_MODE_RMII     = 3'h1,
      PSL_MODE_SMII     = 3'h2,
      PSL_MODE_RSVD3    = 3'h3,
      PSL_MODE_MII_PRE  = 3'h4,
      PSL_MODE_RMII_B2B = 3'h5,
      PSL_MODE_MII_B2B  = 3'h6,
      PSL_MODE_RSVD7    = 3'h7
   } psl_mode_t;
endpackage

/* File: verilog/psl_sync.sv */
`timescale 1ns/100ps
// Two-flop level synchroniser, one per bit
module psl_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_q  <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule

/* File: verilog/psl_mii_link.sv */
`timescale 1ns/100ps
// Link-side logic on the reference clock: drives MII receive outputs and clocks
module psl_mii_link (
   // Link clock domain
   input  wire logic       ref_clock_in,
   input  wire logic       linkRst,
   // Receive stream from core
   input  wire logic       rxActive,
   input  wire logic [3:0] rxNibble,
   input  wire logic       rxBad,
   // MII outputs
   output logic            rxClk,
   output logic            txClk,
   output logic [3:0]      rxData,
   output logic            rxDataValid,
   output logic            rxErr,
   output logic            driveEn
);
   logic linkRstMeta;
   logic linkRstSync;
   logic [5:0] rxSync;

   // Reset crosses into the link domain by two flops
   always_ff @(posedge ref_clock_in)
   begin
      linkRstMeta <= linkRst;
      linkRstSync <= linkRstMeta;
   end

   psl_sync #(.WIDTH(6)) u_rxs (
      .clk     (ref_clock_in),
      .srst    (linkRstSync),
      .asyncIn ({rxActive, rxBad, rxNibble}),
      .syncOut (rxSync)
   );

   // Receive outputs only after reset released; straps see the pins until then
   always_ff @(posedge ref_clock_in)
   begin
      if (linkRstSync)
      begin
         rxData      <= 4'h0;
         rxDataValid <= 1'b0;
         rxErr       <= 1'b0;
         driveEn     <= 1'b0;
      end
      else
      begin
         driveEn     <= 1'b1;
         rxDataValid <= rxSync[5];
         rxErr       <= rxSync[4];
         rxData      <= rxSync[5] ? rxSync[3:0] : 4'h0;
      end
   end

   // Clocks are taken from the single reference
   assign rxClk = ref_clock_in;
   assign txClk = ref_clock_in;
endmodule

/* File: test/psl_strap_top_checker.sv */
`timescale 1ns/100ps
// Strap latching, pin drive, interrupt idle level and bus answer timing at the top ports
module psl_strap_top_checker (
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               srst,
   // Strap pins and results
   input wire logic [3:0]         rxdIn,
   input wire logic               rxdvIn,
   input wire logic               rxPinsOe,
   input wire logic [4:0]         station_address,
   input wire psl_pkg::psl_mode_t ifMode,
   input wire logic               modeReserved,
   input wire logic               irq_out,
   // Bus answers
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [1:0]         s_axi_bresp
);
   logic [3:0] runCnt_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // Cycles since release, saturating; straps must be frozen well before it tops out
   always_ff @(posedge core_clk)
      if (srst)
         runCnt_q <= 4'h0;
      else if (runCnt_q != 4'hf)
         runCnt_q <= runCnt_q + 4'h1;

   addr_upper_a: assert property (station_address[4:3] == 2'b00)
      else $error("station address upper bits not zero");
   mode_rsvd_a: assert property (modeReserved == (ifMode[1:0] == 2'b11))
      else $error("reserved mode flag wrong");
   strap_latch_a: assert property (
      $fell(srst) && $stable(rxdIn) && rxdIn == $past(rxdIn, 4)
      |-> station_address[2:0] == {rxdIn[1], rxdIn[2], rxdIn[3]} && ifMode[2] == rxdvIn)
      else $error("strap values not taken from pins");
   strap_hold_a: assert property (
      runCnt_q == 4'hf |-> $stable(station_address) && $stable(ifMode))
      else $error("straps changed after sampling");
   pins_oe_a: assert property ($fell(srst) |-> !rxPinsOe [*4] ##[1:12] rxPinsOe)
      else $error("receive pin drive timing wrong");
   irq_idle_a: assert property ($fell(srst) |-> irq_out [*2])
      else $error("interrupt not idle high after reset");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not withdrawn");

   cover property (modeReserved);
   cover property (!irq_out);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind psl_strap_top psl_strap_top_checker psl_strap_top_checker_i (
   .core_clk(core_clk), .srst(srst), .rxdIn(rxdIn), .rxdvIn(rxdvIn), .rxPinsOe(rxPinsOe),
   .station_address(station_address), .ifMode(ifMode), .modeReserved(modeReserved),
   .irq_out(irq_out), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp));

/* File: test/psl_mac_model.sv */
`timescale 1ns/100ps
// MAC side: strap pulls on the shared pins, transmit stream, management lines passed on from the bench controller
module psl_mac_model (
   // From the device
   input wire logic       txClk,
   input wire logic       rxPinsOe,
   input wire logic [3:0] rxdOut,
   input wire logic       rxdvOut,
   input wire logic       rxerOut,
   // Pull levels {rxer, rxdv, rxd} and transmit request from the bench
   input wire logic [5:0] strapPull,
   input wire logic       txGo,
   // Management clock and data level from the bench controller
   input wire logic       mgmtTick,
   input wire logic       mgmtBit,
   // Resolved pins and MAC outputs
   output logic [3:0]     rxdIn,
   output logic           rxdvIn,
   output logic           rxerIn,
   output logic           txEn,
   output logic [3:0]     txData,
   output logic           mgmtClk,
   output logic           mgmtDataIn
);
   // Pins show the device drive when enabled, otherwise the pull level
   assign rxdIn  = rxPinsOe ? rxdOut : strapPull[3:0];
   assign rxdvIn = rxPinsOe ? rxdvOut : strapPull[4];
   assign rxerIn = rxPinsOe ? rxerOut : strapPull[5];
   // Controller clock stands still between bits; released data rests at its pull-up
   assign mgmtClk    = mgmtTick;
   assign mgmtDataIn = mgmtBit;

   initial
   begin
      txEn   = 1'b0;
      txData = 4'h0;
   end
   // Nibbles launched on the device transmit clock; idle data flips so it never looks valid
   always @(posedge txClk)
   begin
      txEn   <= txGo;
      txData <= txGo ? txData + 4'h1 : ~txData;
   end
endmodule

/* File: test/test_psl_strap_top.sv */
`timescale 1ns/100ps
// Strap latching over all mode codes, link pins, interrupt register and bus refusals
module test_psl_strap_top;
   logic core_clk, srst, ref_clock_in, rxdvIn, rxerIn, rxdvOut, rxerOut, rxPinsOe, txGo;
   logic rxClk, txClk, rxActive, rxBad, txEn, txEnSeen, mgmtClk, mgmtDataIn, modeReserved;
   logic irq_out, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, mgmtTick, mgmtBit;
   logic [3:0]  rxdIn, rxdOut, rxNibble, txData;
   logic [1:0]  ifModeLow, br, rr, r;
   logic [5:0]  strapPull;
   logic [4:0]  station_address;
   logic [7:0]  aw, ar;
   logic [31:0] wd, rd, d;
   psl_pkg::psl_mode_t ifMode;
   int          fails, total_checks, seed, k, p, a, en, ev, sts, pol;

   psl_strap_top psl_strap_top_i (.core_clk(core_clk), .srst(srst), .ref_clock_in(ref_clock_in),
      .rxdIn(rxdIn), .rxdvIn(rxdvIn), .rxerIn(rxerIn), .rxdOut(rxdOut), .rxdvOut(rxdvOut),
      .rxerOut(rxerOut), .rxPinsOe(rxPinsOe), .rxClk(rxClk), .txClk(txClk),
      .ifModeLow(ifModeLow), .rxActive(rxActive), .rxNibble(rxNibble), .rxBad(rxBad),
      .txEn(txEn), .txData(txData), .mgmtClk(mgmtClk), .mgmtDataIn(mgmtDataIn),
      .mgmtDataOut(), .mgmtDataOe(), .station_address(station_address), .ifMode(ifMode),
      .modeReserved(modeReserved), .txEnSeen(txEnSeen), .irq_out(irq_out),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre));

   psl_mac_model psl_mac_model_i (.txClk(txClk), .rxPinsOe(rxPinsOe), .rxdOut(rxdOut),
      .rxdvOut(rxdvOut), .rxerOut(rxerOut), .strapPull(strapPull), .txGo(txGo),
      .rxdIn(rxdIn), .rxdvIn(rxdvIn), .rxerIn(rxerIn), .txEn(txEn), .txData(txData),
      .mgmtTick(mgmtTick), .mgmtBit(mgmtBit), .mgmtClk(mgmtClk), .mgmtDataIn(mgmtDataIn));

   // Core clock, and a link clock of unrelated phase
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      ref_clock_in = 1'b0;
      #1.7;
      forever #3 ref_clock_in = ~ref_clock_in;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address and data offered together; each released when taken
   task automatic axiWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      bit done;
      done = 0;
      aw <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      // Only the watchdog ends a wait for the answer
      while (!done)
      begin
         @(posedge core_clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bv)
         begin
            resp = br;
            bre <= 1'b0;
            done = 1;
         end
      end
      @(posedge core_clk);
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      bit done;
      done = 0;
      ar <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      while (!done)
      begin
         @(posedge core_clk);
         if (arv && arr) arv <= 1'b0;
         if (rv)
         begin
            v = rd;
            resp = rr;
            rre <= 1'b0;
            done = 1;
         end
      end
      @(posedge core_clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cut a hang short; the whole run needs about four hundred cycles
   initial
   begin
      repeat (5000) @(posedge core_clk);
      fails++;
      report_and_stop;
   end

   initial
   begin
      seed = 53401;
      {srst, txGo, rxActive, rxBad, awv, wv, bre, arv, rre, mgmtTick, mgmtBit} = 11'h401;
      {rxNibble, ifModeLow, strapPull, aw, ar, wd} = '0;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      // First release runs into the run phase before the loop resets again
      repeat (8) @(posedge core_clk);
      // Every mode code with random address, duplex and isolate pulls
      for (k = 0; k < 8; k++)
      begin
         p = $random(seed);
         p[4] = k[2];
         a = p[3] + 2 * p[2] + 4 * p[1];
         strapPull <= p[5:0];
         ifModeLow <= k[1:0];
         rxActive <= 1'b0;
         srst <= 1'b1;
         repeat (6) @(posedge core_clk);
         srst <= 1'b0;
         repeat (12) @(posedge core_clk);
         chk("address", a, station_address);
         chk("mode", k, ifMode);
         chk("reserved", k % 4 == 3, modeReserved);
         chk("rxdv idle", 0, rxdvOut);
         chk("tx idle", 0, txEnSeen);
         axiRd(psl_pkg::CTRL_OFS, d, r);
         chk("ctrl", p[5] * 1024 + p[0] * 256, d);
         axiRd(psl_pkg::STRAP_OFS, d, r);
         chk("strap reg", (k % 4 == 3) * 2048 + k * 256 + 192 + a, d);
         // Pins now carry receive traffic and the mode straps move
         rxNibble <= 4'($random(seed));
         rxBad <= 1'($random(seed));
         rxActive <= 1'b1;
         ifModeLow <= ~k[1:0];
         txGo <= 1'b1;
         repeat (8) @(posedge core_clk);
         chk("rxd", rxNibble, rxdOut);
         chk("rxdv", 1, rxdvOut);
         chk("rxer", rxBad, rxerOut);
         chk("tx enable", 1, txEnSeen);
         chk("address held", a, station_address);
         chk("mode held", k, ifMode);
         txGo <= 1'b0;
      end
      $display("strap test done");
      // Enabled and masked events under both polarities
      sts = 0;
      for (k = 0; k < 4; k++)
      begin
         pol = k % 2;
         en = ($random(seed) & 255) | 1;
         ev = (k < 2) ? en : (~en & 255);
         axiWr(psl_pkg::PHYCTL_OFS, pol << 9, r);
         chk("bresp", psl_pkg::RESP_OKAY, r);
         axiWr(psl_pkg::IRQ_OFS, en << 8, r);
         axiRd(psl_pkg::IRQ_OFS, d, r);
         chk("irq reg", en * 256 + sts, d);
         sts = 0;
         repeat (2) @(posedge core_clk);
         chk("irq idle", !pol, irq_out);
         axiWr(psl_pkg::EVENT_OFS, ev, r);
         sts = ev;
         repeat (2) @(posedge core_clk);
         chk("irq pin", pol ? (sts & en) != 0 : (sts & en) == 0, irq_out);
      end
      axiRd(psl_pkg::PHYCTL_OFS, d, r);
      chk("polarity reg", 512, d);
      $display("interrupt test done");
      // One low data bit clocked in by the controller, then the line is released
      mgmtBit <= 1'b0;
      repeat (2) @(posedge core_clk);
      mgmtTick <= 1'b1;
      repeat (4) @(posedge core_clk);
      mgmtTick <= 1'b0;
      mgmtBit <= 1'b1;
      repeat (4) @(posedge core_clk);
      axiRd(psl_pkg::STRAP_OFS, d, r);
      chk("mgmt bit", 0, d[7]);
      $display("management test done");
      axiRd(8'h40, d, r);
      chk("unmapped read", psl_pkg::RESP_SLVERR, r);
      chk("unmapped data", 0, d);
      axiWr(8'h44, 32'h0000_00ff, r);
      chk("unmapped write", psl_pkg::RESP_SLVERR, r);
      $display("refusal test done");
      report_and_stop;
   end
endmodule
